//--- core/otc_consts.svh
/*
 Shared constants for the output tristate control block: register offset,
 field positions, reset value and group indices.
 Assumes it is included by the package; the design modules use its macros without including it.
*/
`ifndef OTC_CONSTS_SVH
`define OTC_CONSTS_SVH

`define OTC_REG_OFFSET      8'hf2
`define OTC_REG_RESET       8'h00
`define OTC_BIT_OUT_EN      0
`define OTC_BIT_PIN_DIS     1
`define OTC_BIT_LATCH_SEL   2
`define OTC_BIT_DELAY       3
`define OTC_NUM_GROUPS      9
`define OTC_GRP_HORIZ_REF   0
`define OTC_GRP_VREF        1
`define OTC_GRP_FIELD       2
`define OTC_GRP_ACTIVE_QUAL 3
`define OTC_GRP_LINE_CLK    4
`define OTC_GRP_PIXEL_CLK   5
`define OTC_GRP_PORTA       6
`define OTC_GRP_PORTB       7
`define OTC_GRP_TDO         8

`endif

//--- core/otc_pkg.sv
/*
 Types for the output tristate control block.
 Assumes the constants header sits beside it.
*/
`include "otc_consts.svh"

package otc_pkg;

	typedef enum logic [1:0] {
		OTC_TAP_NORMAL = 2'b00,
		OTC_TAP_EXTEST = 2'b01,
		OTC_TAP_CLAMP  = 2'b11,
		OTC_TAP_HIGHZ  = 2'b10
	} otc_tap_mode_t;

	typedef struct packed {
		otc_tap_mode_t                   mode;
		logic [`OTC_NUM_GROUPS-1:0]      cellEn;
	} otc_tap_ctrl_t;

	typedef struct packed {
		logic       wrStb;
		logic [7:0] addr;
		logic [7:0] wrData;
	} otc_reg_wr_t;

endpackage

//--- core/otc_pin_sync.sv
/*
 Two-flop synchroniser followed by the enable-pin conditioning: optional
 capture on the line-locked clock and an optional extra line-locked clock period of delay.
 Assumes the line-locked clock tick is a one-cycle pulse in clk_sys.
*/
`timescale 1ns/1ps

module otc_pin_sync
	import otc_pkg::*;
(
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Pin and controls.
	input  wire logic portEnPinN,
	input  wire logic lineTick,
	input  wire logic latchSel,
	input  wire logic delaySel,
	// Result.
	output logic      portEnN
);

	logic syncA_q;
	logic syncB_q;
	logic latched_q;
	logic delayed_q;
	logic base;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			syncA_q   <= 1'b1;
			syncB_q   <= 1'b1;
			latched_q <= 1'b1;
			delayed_q <= 1'b1;
		end else begin
			syncA_q <= portEnPinN;
			syncB_q <= syncA_q;
			if (lineTick) begin
				latched_q <= syncB_q;
				delayed_q <= base;
			end
		end
	end

	assign base    = latchSel ? latched_q : syncB_q;
	assign portEnN = delaySel ? delayed_q : base;

endmodule // otc_pin_sync

//--- core/otc_output_ctrl.sv
/*
 Output tristate control: one output enable per output group, from a strict
 priority chain of test access port state, chip reset, the output driver
 control register and the active-low video-port enable pin; TDO follows only the test access port state.
 Assumes the TAP controller and the serial-bus slave are outside and hand in
 their state on the same clock; the enable pin and chip reset are pins.
*/
`timescale 1ns/1ps

module otc_output_ctrl
	import otc_pkg::*;
(
	// Clock and reset.
	input  wire logic                       clk_sys,
	input  wire logic                       rstn,
	// Chip pins.
	input  wire logic                       chip_reset_n,
	input  wire logic                       portEnPinN,
	input  wire logic                       line_locked_clock,
	// Test access port state.
	input  otc_tap_ctrl_t                   tapCtrl,
	// Serial-bus register access.
	input  otc_reg_wr_t                     regWr,
	output logic [7:0]                      regRdData,
	// Output enables, one per group.
	output logic [`OTC_NUM_GROUPS-1:0]      groupOe
);

	logic [7:0]                 ctrl_q;
	logic [7:0]                 ctrl_d;
	logic                       rstSyncA_q;
	logic                       rstSyncB_q;
	logic                       lineSyncA_q;
	logic                       lineSyncB_q;
	logic                       linePrev_q;
	logic                       lineTick;
	logic                       portEnN;
	logic [`OTC_NUM_GROUPS-1:0] oe_d;
	logic [`OTC_NUM_GROUPS-1:0] oe_q;

	// Named decodes of the controls.
	wire regHit     = regWr.wrStb && (regWr.addr == `OTC_REG_OFFSET);
	wire outEn      = ctrl_q[`OTC_BIT_OUT_EN];
	wire pinDis     = ctrl_q[`OTC_BIT_PIN_DIS];
	wire scanMode   = (tapCtrl.mode == OTC_TAP_EXTEST) || (tapCtrl.mode == OTC_TAP_CLAMP);
	wire highzMode  = (tapCtrl.mode == OTC_TAP_HIGHZ);
	wire inReset    = !rstSyncB_q;
	wire dataEn     = pinDis || !portEnN;

	assign ctrl_d = regHit ? regWr.wrData : ctrl_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_q     <= `OTC_REG_RESET;
			rstSyncA_q <= 1'b0;
			rstSyncB_q <= 1'b0;
			lineSyncA_q <= 1'b0;
			lineSyncB_q <= 1'b0;
			linePrev_q  <= 1'b0;
			oe_q       <= '0;
		end else begin
			ctrl_q     <= ctrl_d;
			rstSyncA_q <= chip_reset_n;
			rstSyncB_q <= rstSyncA_q;
			lineSyncA_q <= line_locked_clock;
			lineSyncB_q <= lineSyncA_q;
			linePrev_q  <= lineSyncB_q;
			oe_q       <= oe_d;
		end
	end

	// Rising edges of the line-locked clock, seen after synchronisation.
	assign lineTick = lineSyncB_q && !linePrev_q;

	otc_pin_sync u_pin_sync (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.portEnPinN (portEnPinN),
		.lineTick   (lineTick),
		.latchSel   (ctrl_q[`OTC_BIT_LATCH_SEL]),
		.delaySel   (ctrl_q[`OTC_BIT_DELAY]),
		.portEnN    (portEnN)
	);

	// The chain is evaluated per group, test state first; the enable pin is
	// only consulted after reset and the register enable have let it through.
	genvar g;
	generate
		for (g = 0; g < `OTC_NUM_GROUPS; g++) begin : gGroup
			localparam bit IS_DATA = (g == `OTC_GRP_PORTA) || (g == `OTC_GRP_PORTB);
			localparam bit IS_PIX  = (g == `OTC_GRP_PIXEL_CLK);
			localparam bit IS_TDO  = (g == `OTC_GRP_TDO);
			always_comb begin
				if (highzMode) begin
					oe_d[g] = 1'b0;
				end else if (scanMode) begin
					oe_d[g] = tapCtrl.cellEn[g];
				end else if (IS_TDO) begin
					oe_d[g] = 1'b1;
				end else if (inReset) begin
					oe_d[g] = 1'b0;
				end else if (!outEn) begin
					oe_d[g] = IS_PIX;
				end else if (IS_DATA) begin
					oe_d[g] = dataEn;
				end else begin
					oe_d[g] = 1'b1;
				end
			end
		end
	endgenerate

	assign groupOe   = oe_q;
	assign regRdData = ctrl_q;

endmodule // otc_output_ctrl

//--- sim/otc_chk.sv
/* Port assertions for the tristate block.
   Assumes it is bound to otc_output_ctrl. */
`timescale 1ns/1ps
module otc_chk
	import otc_pkg::*;
(
	// Watched ports.
	input wire logic     clk_sys,
	input wire logic     rstn,
	input wire logic     chip_reset_n,
	input wire logic     portEnPinN,
	input otc_tap_ctrl_t tapCtrl,
	input otc_reg_wr_t   regWr,
	input logic [7:0]    regRdData,
	input logic [8:0]    groupOe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	wire [1:0] mode = tapCtrl.mode;
	wire       run  = !mode && chip_reset_n;
	chk_highz_off: assert property ((mode == OTC_TAP_HIGHZ)[*2] |=> !groupOe)
		else $error("highz");
	chk_scan_cells: assert property (mode[0][*2] |=> groupOe == $past(tapCtrl.cellEn))
		else $error("scan");
	chk_tdo_kept: assert property ((!mode)[*3] |=> groupOe[8])
		else $error("tdo");
	chk_reset_off: assert property ((!mode && !chip_reset_n)[*4] |=> !groupOe[7:0])
		else $error("reset");
	chk_enable_clr: assert property ((run && !regRdData[0])[*4] |=> groupOe[7:0] == 8'h20)
		else $error("enable");
	chk_pin_direct: assert property ((run && regRdData[3:0] == 4'h1 && $stable(portEnPinN))[*4] |=>
		groupOe[7:0] == {{2{!$past(portEnPinN)}}, 6'h3f}) else $error("pin");
	chk_pin_ignored: assert property ((run && regRdData[1:0] == 2'b11)[*4] |=> groupOe == 9'h1ff)
		else $error("disable");
	chk_write_take: assert property (regWr.wrStb && regWr.addr == 8'hf2 |=> regRdData == $past(regWr.wrData))
		else $error("write");
	cover property (mode == OTC_TAP_CLAMP);
	cover property (groupOe == 9'h1ff);
	cover property (groupOe == 9'h13f);
endmodule // otc_chk
bind otc_output_ctrl otc_chk otc_chk_i (.*);

//--- sim/otc_host_model.sv
/* Serial-bus host, TAP state and free-running line clock.
   Assumes its tasks are called between clock edges. */
`timescale 1ns/1ps
module otc_host_model
	import otc_pkg::*;
(
	// Clock in, stimulus out.
	input  wire logic     clk_sys,
	output logic          line_locked_clock,
	output otc_tap_ctrl_t tapCtrl,
	output otc_reg_wr_t   regWr
);
	initial {line_locked_clock, tapCtrl, regWr} = '0;
	always #18.519 line_locked_clock = ~line_locked_clock;
	task automatic write(input logic [7:0] a, d);
		@(posedge clk_sys) regWr <= {1'b1, a, d};
		// Released fields show the inverse so a late sample is caught.
		@(posedge clk_sys) regWr <= {1'b0, ~a, ~d};
	endtask
	task automatic scan(input logic [10:0] t);
		@(posedge clk_sys) tapCtrl <= t;
	endtask
endmodule // otc_host_model

//--- sim/otc_output_ctrl_tb.sv
/* Self-checking bench for the tristate block.
   Assumes the host model drives writes, TAP state and line clock. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module otc_output_ctrl_tb
	import otc_pkg::*;
();
	logic          clk_sys = 1'b0, rstn = 1'b0, chip_reset_n = 1'b1, portEnPinN = 1'b1, line_locked_clock;
	otc_tap_ctrl_t tapCtrl;
	otc_reg_wr_t   regWr;
	logic [7:0]    regRdData;
	logic [8:0]    groupOe;
	int            num_errors = 0, compares = 0, cycles = 0;
	always #5 clk_sys = ~clk_sys;
	otc_host_model otc_host_model_i (.*);
	otc_output_ctrl otc_output_ctrl_i (.*);
	task automatic step(input logic p, input int n);
		@(posedge clk_sys) portEnPinN <= p;
		repeat (n) @(negedge clk_sys);
	endtask
	task final_report;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			final_report();
		end
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		step(1'b1, 4);
		`CHK("reg", 8'h00, regRdData)
		`CHK("idle", 9'h120, groupOe)
		otc_host_model_i.write(8'hf2, 8'h01);
		step(1'b0, 5);
		`CHK("all", 9'h1ff, groupOe)
		step(1'b1, 5);
		`CHK("ports", 9'h13f, groupOe)
		otc_host_model_i.write(8'hf3, 8'h55);
		step(1'b1, 2);
		`CHK("other addr", 8'h01, regRdData)
		otc_host_model_i.write(8'hf2, 8'h03);
		step(1'b1, 4);
		`CHK("reg dis", 8'h03, regRdData)
		`CHK("dis", 9'h1ff, groupOe)
		otc_host_model_i.write(8'hf2, 8'h0d);
		step(1'b1, 24);
		step(1'b0, 4);
		`CHK("held", 9'h13f, groupOe)
		step(1'b0, 24);
		`CHK("latched", 9'h1ff, groupOe)
		@(posedge clk_sys) chip_reset_n <= 1'b0;
		step(1'b1, 5);
		`CHK("chip rst", 9'h100, groupOe)
		for (int i = 1; i < 4; i++) begin
			otc_host_model_i.scan({i[1:0], 9'h0a5 << i});
			step(1'b1, 3);
			`CHK("tap", i == 2 ? 9'h000 : 9'h0a5 << i, groupOe)
		end
		otc_host_model_i.scan(11'h000);
		@(posedge clk_sys) chip_reset_n <= 1'b1;
		step(1'b1, 30);
		`CHK("back", 9'h13f, groupOe)
		final_report();
	end
endmodule // otc_output_ctrl_tb
